// ==== inc/sprs_pkg.sv ====
package sprs_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ          = 200;
  localparam int STRAP_HOLD_US    = 500;
  localparam int STRAP_HOLD_CYC   = STRAP_HOLD_US * CLK_MHZ;
  localparam int DEEP_LOW_US      = 500;
  localparam int DEEP_LOW_CYC     = DEEP_LOW_US * CLK_MHZ;
  localparam int IDLE_SLEEP_CYC   = 2000;
  localparam int FM_RATE_KBPS     = 400;
  localparam int SCL_HALF_CYC     = (CLK_MHZ * 1000) / (FM_RATE_KBPS * 2);
  localparam int CNT_W            = 24;
  // ------------------------------------------------------------
  // addresses
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_LO  = 7'h48;
  localparam logic [6:0] ADDR_HI  = 7'h49;
  // ------------------------------------------------------------
  // power states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SPRS_ST_STRAP = 3'h0,
    SPRS_ST_RUN   = 3'h1,
    SPRS_ST_SLEEP = 3'h3,
    SPRS_ST_DEEP  = 3'h2,
    SPRS_ST_OFF   = 3'h6
  } sprs_pwr_e;
endpackage

// ==== inc/sprs_if.sv ====
`timescale 1ns/10ps
interface sprs_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic sda_host_o;
  logic sda_host_oe_n;
  logic reset_n;
  logic interface_activate_pin;
  logic address_select_pin;
  wire  scl = scl_oe_n ? 1'b1 : scl_o;
  wire  sda = (sda_dev_oe_n ? 1'b1 : sda_dev_o) & (sda_host_oe_n ? 1'b1 : sda_host_o);
  modport dev  (input scl, sda, reset_n, interface_activate_pin, address_select_pin,
                output sda_dev_o, sda_dev_oe_n);
  modport host (input scl, sda, output scl_o, scl_oe_n, sda_host_o, sda_host_oe_n,
                reset_n, interface_activate_pin, address_select_pin);
endinterface

// ==== verilog/sprs_device.sv ====
`timescale 1ns/10ps
// Summary of operation
// - slave only, bus up to fast-mode
// - traffic framed by smartcard serial framing
// - strap sample; low straps disable interface
// - address_select low gives 0x90/0x91
// - address_select high gives 0x92/0x93
// - host holds straps steady 500 us
// - sleep entry and exit are automatic
// - sleep freezes core, keeps contents
// - outputs hold level during sleep
// - tamper sensors disabled in sleep
// - wake on reset or sda fall
// - reset low over 500 us: deep sleep
// - deep sleep cuts power, pads high-z
// - release reset to leave deep sleep
// - host drives interface_activate high
// - reset pin is active low
module sprs_device #(
  parameter int STRAP_CYC = sprs_pkg::STRAP_HOLD_CYC,
  parameter int DEEP_CYC  = sprs_pkg::DEEP_LOW_CYC,
  parameter int IDLE_CYC  = sprs_pkg::IDLE_SLEEP_CYC
) (
  input  wire logic clk,                  // 200 MHz clock
  input  wire logic rst,                  // power-on reset
  sprs_if.dev       bus,                  // pins
  output logic      core_clk_en,          // internal clock enable
  output logic      sensors_en,           // tamper detectors enable
  output logic      core_power_en,        // internal power
  output logic      if_enabled,           // interface enabled
  output logic [7:0] wr_addr_byte,        // latched write address byte
  output logic      sleeping,             // in sleep
  output logic      addr_match            // pulse on own address acked
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] scl_s, sda_s, rst_s, ifa_s, ads_s;
  always_ff @(posedge clk) begin
    scl_s <= {scl_s[0], bus.scl};
    sda_s <= {sda_s[0], bus.sda};
    rst_s <= {rst_s[0], bus.reset_n};
    ifa_s <= {ifa_s[0], bus.interface_activate_pin};
    ads_s <= {ads_s[0], bus.address_select_pin};
  end
  logic scl_d, sda_d;
  always_ff @(posedge clk) begin
    scl_d <= scl_s[1];
    sda_d <= sda_s[1];
  end
  wire scl_rise = scl_s[1] & ~scl_d;
  wire scl_fall = ~scl_s[1] & scl_d;
  wire sda_fall = ~sda_s[1] & sda_d;
  wire start_c  = sda_fall & scl_s[1];
  wire stop_c   = sda_s[1] & ~sda_d & scl_s[1];
  wire rst_low  = ~rst_s[1];
  // ------------------------------------------------------------
  // power state machine
  // ------------------------------------------------------------
  sprs_pkg::sprs_pwr_e st_r;
  logic [sprs_pkg::CNT_W-1:0] strap_cnt_r, deep_cnt_r, idle_cnt_r;
  logic busy_r;
  always_ff @(posedge clk) begin
    if (rst || rst_low) begin
      strap_cnt_r <= '0;
    end else if (st_r == sprs_pkg::SPRS_ST_STRAP) begin
      strap_cnt_r <= strap_cnt_r + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || !rst_low) begin
      deep_cnt_r <= '0;
    end else if (deep_cnt_r < sprs_pkg::CNT_W'(DEEP_CYC)) begin
      deep_cnt_r <= deep_cnt_r + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || st_r != sprs_pkg::SPRS_ST_RUN || busy_r || start_c) begin
      idle_cnt_r <= '0;
    end else if (idle_cnt_r < sprs_pkg::CNT_W'(IDLE_CYC)) begin
      idle_cnt_r <= idle_cnt_r + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= sprs_pkg::SPRS_ST_STRAP;
    end else begin
      case (st_r)
        sprs_pkg::SPRS_ST_STRAP: begin
          if (deep_cnt_r == sprs_pkg::CNT_W'(DEEP_CYC)) begin
            st_r <= sprs_pkg::SPRS_ST_DEEP;
          end else if (rst_low) begin
            st_r <= sprs_pkg::SPRS_ST_STRAP;
          end else if (strap_cnt_r == sprs_pkg::CNT_W'(STRAP_CYC - 1)) begin
            st_r <= sprs_pkg::SPRS_ST_RUN;
          end
        end
        sprs_pkg::SPRS_ST_RUN: begin
          if (deep_cnt_r == sprs_pkg::CNT_W'(DEEP_CYC)) begin
            st_r <= sprs_pkg::SPRS_ST_DEEP;
          end else if (rst_low) begin
            st_r <= sprs_pkg::SPRS_ST_STRAP;
          end else if (idle_cnt_r == sprs_pkg::CNT_W'(IDLE_CYC)) begin
            st_r <= sprs_pkg::SPRS_ST_SLEEP;
          end
        end
        sprs_pkg::SPRS_ST_SLEEP: begin
          if (rst_low) begin
            st_r <= sprs_pkg::SPRS_ST_STRAP;
          end else if (sda_fall) begin
            st_r <= sprs_pkg::SPRS_ST_RUN;
          end
        end
        sprs_pkg::SPRS_ST_DEEP: begin
          if (!rst_low) begin
            st_r <= sprs_pkg::SPRS_ST_STRAP;
          end
        end
        default: st_r <= sprs_pkg::SPRS_ST_STRAP;
      endcase
    end
  end
  // deep entry from strap or run once reset has been low long enough; sleep goes to strap first
  wire in_deep = (st_r == sprs_pkg::SPRS_ST_DEEP);
  // ------------------------------------------------------------
  // strap latch
  // ------------------------------------------------------------
  logic en_r, sel_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      en_r  <= 1'b0;
      sel_r <= 1'b0;
    end else if (st_r == sprs_pkg::SPRS_ST_STRAP && !rst_low
                 && strap_cnt_r == sprs_pkg::CNT_W'(STRAP_CYC - 1)) begin
      en_r  <= ifa_s[1] & scl_s[1] & sda_s[1];
      sel_r <= ads_s[1];
    end
  end
  wire [6:0] own_addr = sel_r ? sprs_pkg::ADDR_HI : sprs_pkg::ADDR_LO;
  // ------------------------------------------------------------
  // address byte receiver, slave only
  // ------------------------------------------------------------
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r;
  logic       ack_r, hold_r;
  wire run = (st_r == sprs_pkg::SPRS_ST_RUN) && en_r;
  always_ff @(posedge clk) begin
    if (rst || !run || stop_c) begin
      busy_r    <= 1'b0;
      bit_cnt_r <= 4'h0;
      sh_r      <= 8'h00;
    end else if (start_c) begin
      busy_r    <= 1'b1;
      bit_cnt_r <= 4'h0;
    end else if (busy_r && scl_rise && bit_cnt_r < 4'h8) begin
      sh_r      <= {sh_r[6:0], sda_s[1]};
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end else if (busy_r && scl_fall && bit_cnt_r == 4'h9) begin
      bit_cnt_r <= 4'ha;
    end else if (busy_r && scl_fall && bit_cnt_r == 4'h8) begin
      bit_cnt_r <= 4'h9;
    end
  end
  // acknowledge own address; further framing is done by the framing layer
  always_ff @(posedge clk) begin
    if (rst || !run || stop_c) begin
      ack_r      <= 1'b0;
      addr_match <= 1'b0;
    end else begin
      addr_match <= 1'b0;
      if (busy_r && scl_fall && bit_cnt_r == 4'h8 && sh_r[7:1] == own_addr) begin
        ack_r      <= 1'b1;
        addr_match <= 1'b1;
      end else if (scl_fall && bit_cnt_r == 4'h9) begin
        ack_r <= 1'b0;
      end
    end
  end
  // sda output: hold level in sleep, high-z in deep sleep
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_r <= 1'b0;
    end else if (st_r != sprs_pkg::SPRS_ST_SLEEP) begin
      hold_r <= ack_r;
    end
  end
  assign bus.sda_dev_o    = 1'b0;
  assign bus.sda_dev_oe_n = in_deep ? 1'b1 : ~hold_r;
  // ------------------------------------------------------------
  // status outputs
  // ------------------------------------------------------------
  assign sleeping      = (st_r == sprs_pkg::SPRS_ST_SLEEP);
  assign core_clk_en   = !sleeping && !in_deep;
  assign sensors_en    = !sleeping && !in_deep;
  assign core_power_en = !in_deep;
  assign if_enabled    = en_r;
  assign wr_addr_byte  = en_r ? {own_addr, 1'b0} : 8'h00;
endmodule

// ==== verilog/sprs_host.sv ====
`timescale 1ns/10ps
module sprs_host #(
  parameter int HALF_CYC = sprs_pkg::SCL_HALF_CYC
) (
  input  wire logic       clk,             // 200 MHz clock
  input  wire logic       rst,             // synchronous reset
  sprs_if.host            bus,             // pins
  input  wire logic       strap_act,       // interface_activate level
  input  wire logic       strap_sel,       // address_select level
  input  wire logic       hold_reset,      // drive reset pin low
  input  wire logic       req,             // send address byte
  input  wire logic [7:0] addr_byte,       // byte to send
  output logic            ready,           // idle
  output logic            done,            // pulse at end
  output logic            acked            // device acknowledged
);
  // ------------------------------------------------------------
  // strap and reset pins
  // ------------------------------------------------------------
  assign bus.interface_activate_pin = strap_act;
  assign bus.address_select_pin     = strap_sel;
  assign bus.reset_n                = ~hold_reset;
  // ------------------------------------------------------------
  // bit-rate divider and address sender
  // ------------------------------------------------------------
  logic [15:0] div_r;
  logic [5:0]  ph_r;
  logic [7:0]  sh_r;
  logic        busy_r, scl_r, sda_r;
  logic [1:0]  sda_s;
  wire tick = (div_r == 16'(HALF_CYC - 1));
  always_ff @(posedge clk) begin
    sda_s <= {sda_s[0], bus.sda};
  end
  always_ff @(posedge clk) begin
    if (rst || !busy_r || tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end
  // phases: 0 start, 1..18 nine bits (low/high), 19 low, 20 stop
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      ph_r   <= 6'h00;
      scl_r  <= 1'b1;
      sda_r  <= 1'b1;
      sh_r   <= 8'h00;
      done   <= 1'b0;
      acked  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy_r && req) begin
        busy_r <= 1'b1;
        ph_r   <= 6'h00;
        sh_r   <= addr_byte;
        sda_r  <= 1'b0;
      end else if (busy_r && tick) begin
        ph_r <= ph_r + 6'h01;
        if (ph_r < 6'h12) begin
          scl_r <= ph_r[0];
          if (!ph_r[0]) begin
            sda_r <= (ph_r < 6'h10) ? sh_r[7] : 1'b1;
            if (ph_r < 6'h10) begin
              sh_r <= {sh_r[6:0], 1'b0};
            end
          end
          if (ph_r == 6'h11) begin
            acked <= ~sda_s[1];
          end
        end else if (ph_r == 6'h12) begin
          scl_r <= 1'b0;
          sda_r <= 1'b0;
        end else if (ph_r == 6'h13) begin
          scl_r <= 1'b1;
        end else begin
          sda_r  <= 1'b1;
          busy_r <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end
  assign bus.scl_o         = 1'b0;
  assign bus.scl_oe_n      = scl_r;
  assign bus.sda_host_o    = 1'b0;
  assign bus.sda_host_oe_n = sda_r;
  assign ready             = !busy_r;
endmodule

// ==== verification/sprs_properties.sv ====
`timescale 1ns/10ps
module sprs_properties #(
  parameter int STRAP_CYC = 50,
  parameter int DEEP_CYC  = 200
) (
  input wire logic       clk,                // clock
  input wire logic       rst,                // reset
  input wire logic       reset_n,            // reset pin
  input wire logic       address_select_pin, // address strap
  input wire logic       sda_dev_oe_n,       // device sda enable
  input wire logic       core_clk_en,        // core clocks
  input wire logic       sensors_en,         // tamper sensors
  input wire logic       core_power_en,      // core power
  input wire logic       if_enabled,         // interface enabled
  input wire logic [7:0] wr_addr_byte,       // write address byte
  input wire logic       sleeping            // sleep state
);
  // ------------------------------------------------------------
  // cycle counters since reset release and since reset pin fell
  // ------------------------------------------------------------
  logic [23:0] up_r;
  logic [23:0] low_r;
  always_ff @(posedge clk) begin
    if (rst) up_r <= 24'h0;
    else if (up_r != 24'hffffff) up_r <= up_r + 24'h1;
  end
  always_ff @(posedge clk) begin
    if (rst || reset_n) low_r <= 24'h0;
    else if (low_r != 24'hffffff) low_r <= low_r + 24'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  sequence s_release;
    $rose(reset_n) && !core_power_en;
  endsequence
  sequence s_power_back;
    ##[1:8] core_power_en;
  endsequence
  AST_SLEEP_CLK: assert property (sleeping |-> !core_clk_en)
    else $error("core clock running in sleep");
  AST_SLEEP_SENS: assert property (sleeping |-> !sensors_en)
    else $error("tamper sensors on in sleep");
  AST_SLEEP_HOLD: assert property (sleeping && $past(sleeping) |-> $stable(sda_dev_oe_n))
    else $error("sda output changed in sleep");
  AST_DEEP_PADS: assert property (!core_power_en |-> sda_dev_oe_n)
    else $error("sda driven in deep sleep");
  AST_ADDR_SEL: assert property (if_enabled |->
    wr_addr_byte == (address_select_pin ? 8'h92 : 8'h90))
    else $error("wrong address byte latched");
  AST_DISABLED: assert property (!if_enabled |-> wr_addr_byte == 8'h00 && sda_dev_oe_n)
    else $error("disabled interface active");
  AST_STRAP_TIME: assert property ($rose(if_enabled) |-> up_r >= STRAP_CYC)
    else $error("interface enabled before strap interval");
  AST_DEEP_ENTRY: assert property ($fell(core_power_en) |-> low_r >= DEEP_CYC)
    else $error("deep sleep entered too early");
  AST_DEEP_EXIT: assert property (s_release |-> s_power_back)
    else $error("deep sleep not left after release");
endmodule

// ==== verification/startup_interface_and_power_modes_test.sv ====
`timescale 1ns/10ps
module startup_interface_and_power_modes_test;
  logic       clk, rst, strap_act, strap_sel, hold_reset, req, ready, done, acked;
  logic       core_clk_en, sensors_en, core_power_en, if_enabled, sleeping, addr_match;
  logic [7:0] addr_byte, wr_addr_byte;
  int         fail_count, n_tests;
  sprs_if bus_if ();
  sprs_device #(.STRAP_CYC(50), .DEEP_CYC(200), .IDLE_CYC(1000)) u_sprs_device (
    .clk(clk), .rst(rst), .bus(bus_if), .core_clk_en(core_clk_en), .sensors_en(sensors_en),
    .core_power_en(core_power_en), .if_enabled(if_enabled), .wr_addr_byte(wr_addr_byte),
    .sleeping(sleeping), .addr_match(addr_match));
  sprs_host #(.HALF_CYC(20)) u_sprs_host (
    .clk(clk), .rst(rst), .bus(bus_if), .strap_act(strap_act), .strap_sel(strap_sel),
    .hold_reset(hold_reset), .req(req), .addr_byte(addr_byte), .ready(ready), .done(done),
    .acked(acked));
  sprs_properties u_sprs_properties (
    .clk(clk), .rst(rst), .reset_n(bus_if.reset_n), .address_select_pin(bus_if.address_select_pin),
    .sda_dev_oe_n(bus_if.sda_dev_oe_n), .core_clk_en(core_clk_en), .sensors_en(sensors_en),
    .core_power_en(core_power_en), .if_enabled(if_enabled), .wr_addr_byte(wr_addr_byte),
    .sleeping(sleeping));
  always #2.5 clk = ~clk;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task por(input logic a, input logic s);
    rst = 1'b1;
    strap_act = a;
    strap_sel = s;
    wait_cyc(5);
    rst = 1'b0;
    wait_cyc(10);
    chk("if_enabled early", 8'h00, if_enabled);
    wait_cyc(70);
  endtask
  task xfer(input logic [7:0] b, input logic exp);
    int   i;
    logic seen;
    seen = 1'b0;
    for (i = 0; i < 2000 && ready !== 1'b1; i++) @(negedge clk);
    addr_byte = b;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    for (i = 0; i < 2000 && done !== 1'b1; i++) begin
      @(negedge clk);
      if (addr_match === 1'b1) seen = 1'b1;
    end
    chk("done", 8'h01, done);
    chk("ready", 8'h01, ready);
    chk("acked", exp, acked);
    chk("addr_match", exp, seen);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_disabled;
    por(1'b0, 1'b0);
    chk("if_enabled", 8'h00, if_enabled);
    chk("wr_addr_byte", 8'h00, wr_addr_byte);
    xfer(8'h90, 1'b0);
    chk("scl idle", 8'h01, bus_if.scl);
    $display("test disabled finished");
  endtask
  task t_addr(input logic s);
    int k;
    por(1'b1, s);
    chk("if_enabled", 8'h01, if_enabled);
    chk("wr_addr_byte", s ? 8'h92 : 8'h90, wr_addr_byte);
    for (k = 0; k < 4; k++) xfer(8'h90 + k[7:0], (k / 2) == s);
    $display("test address select %0d finished", s);
  endtask
  task t_sleep;
    por(1'b1, 1'b0);
    wait_cyc(1200);
    chk("sleeping", 8'h01, sleeping);
    chk("core_clk_en", 8'h00, core_clk_en);
    chk("sensors_en", 8'h00, sensors_en);
    xfer(8'h90, 1'b0);
    chk("sleeping after start", 8'h00, sleeping);
    xfer(8'h90, 1'b1);
    wait_cyc(1200);
    hold_reset = 1'b1;
    wait_cyc(20);
    hold_reset = 1'b0;
    wait_cyc(80);
    chk("sleeping after reset pin", 8'h00, sleeping);
    chk("core_power_en short low", 8'h01, core_power_en);
    $display("test sleep finished");
  endtask
  task t_deep;
    hold_reset = 1'b1;
    wait_cyc(300);
    chk("core_power_en", 8'h00, core_power_en);
    chk("sda_dev_oe_n", 8'h01, bus_if.sda_dev_oe_n);
    chk("sda", 8'h01, bus_if.sda);
    hold_reset = 1'b0;
    wait_cyc(80);
    chk("core_power_en released", 8'h01, core_power_en);
    xfer(8'h90, 1'b1);
    $display("test deep sleep finished");
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    strap_act = 1'b1;
    strap_sel = 1'b0;
    hold_reset = 1'b0;
    req = 1'b0;
    addr_byte = 8'h00;
    fail_count = 0;
    n_tests = 0;
    t_disabled;
    t_addr(1'b0);
    t_addr(1'b1);
    t_sleep;
    t_deep;
    print_verdict;
  end
  // tests take about 8300 cycles; allow about seven times that
  initial begin
    #300000;
    fail_count++;
    print_verdict;
  end
endmodule
